//--- bus_cond_detect.sv
`timescale 1ns/1ps
`default_nettype none
module bus_cond_detect (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic scl_s,
    input  wire logic sda_s,
    output var  logic start_det,
    output var  logic stop_det
);
    // ==========================================
    // Start and stop detection on synced lines
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Data edge while clock stays high
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
endmodule
`default_nettype wire

//--- i2c_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side of the serial bus: lines with pull-ups, a slave that acks
module i2c_bus_peer #(
    parameter real HALF = 32.0
) (
    output var logic scl,
    output var logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Start: data falls while clock high, offset from the system clock phase
    task automatic start_cond;
        #(HALF + 1.3);
        scl = 1'b1;
        sda = 1'b0;
        #(HALF);
        scl = 1'b0;
    endtask

    // Eight data bits then an ack from the slave; data moves only while clock low
    task automatic send_byte(input logic [7:0] b);
        #1.3;
        for (int i = 0; i < 9; i++) begin
            #(HALF / 2);
            sda = (i < 8) ? b[7-i] : 1'b0;
            #(HALF / 2);
            scl = 1'b1;
            #(HALF);
            scl = 1'b0;
        end
    endtask

    // Stop: data rises while clock high, then the bus is released to idle
    task automatic stop_cond;
        #(HALF / 2 + 1.3);
        sda = 1'b0;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF);
        sda = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- i2c_master_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_status_flags #(
    parameter int AW = 12
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [AW-1:0]              paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    input  wire i2c_status_pkg::engine_ev_s engine,
    output var  logic                       irq
);
    import i2c_status_pkg::*;

    // ==========================================
    // Pin synchronisers and bus conditions
    logic [1:0] pins_s;
    logic       start_det;
    logic       stop_det;

    sync_2ff #(
        .W(2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_s)
    );

    bus_cond_detect u_cond (
        .pclk      (pclk),
        .presetn   (presetn),
        .scl_s     (pins_s[1]),
        .sda_s     (pins_s[0]),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // ==========================================
    // APB decode
    logic        setup;
    logic        access;
    logic        wr_done;
    logic        hit_ctl;
    logic        hit_sta;
    logic        sta_read;
    logic [15:0] ctl_r;
    status_s     sta_r;

    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready;
    assign wr_done  = access & pwrite;
    assign hit_ctl  = paddr == AW'(CTL_OFFSET);
    assign hit_sta  = paddr == AW'(STA_OFFSET);
    assign sta_read = access & ~pwrite & hit_sta;

    // Zero-wait answer, ready registered from setup so it is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & ~hit_ctl & ~hit_sta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup & ~pwrite & hit_ctl) begin
            prdata <= {16'h0, ctl_r};
        end else if (setup & ~pwrite & hit_sta) begin
            prdata <= {16'h0, sta_r}; // RQ17
        end else if (setup) begin
            prdata <= 32'h0;
        end
    end

    // ==========================================
    // Master control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= CTL_RESET;
        end else if (wr_done & hit_ctl) begin
            ctl_r <= pwdata[15:0];
        end
    end

    logic en_complete;
    logic en_noack;
    logic en_arb;
    logic en_tx;
    logic en_rx;

    assign en_complete = ctl_r[CTL_COMPLETE_EN]; // RQ18
    assign en_noack    = ctl_r[CTL_NOACK_EN];    // RQ18
    assign en_arb      = ctl_r[CTL_ARB_EN];      // RQ18
    assign en_tx       = ctl_r[CTL_TX_EN];       // RQ18
    assign en_rx       = ctl_r[CTL_RX_EN];       // RQ18

    // ==========================================
    // Status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.bus_busy_flag <= 1'b0; // RQ20
        end else if (start_det) begin
            sta_r.bus_busy_flag <= 1'b1; // RQ1
        end else if (stop_det) begin
            sta_r.bus_busy_flag <= 1'b0; // RQ2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.rx_overflow_flag <= 1'b0;
        end else begin
            sta_r.rx_overflow_flag <= engine.rx_push & engine.rx_full; // RQ3
        end
    end

    // Sticky until status read; a new completion wins over the read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.xfer_complete_flag <= 1'b0;
        end else if (engine.xfer_done) begin
            sta_r.xfer_complete_flag <= 1'b1; // RQ4
        end else if (sta_read) begin
            sta_r.xfer_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.data_no_ack_flag <= 1'b0;
        end else begin
            sta_r.data_no_ack_flag <= engine.data_nack; // RQ6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.master_busy_flag <= 1'b0;
        end else begin
            sta_r.master_busy_flag <= engine.engine_busy & ~engine.arb_lost; // RQ7 RQ8
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.arbitration_lost_status <= 1'b0;
        end else begin
            sta_r.arbitration_lost_status <= engine.arb_lost; // RQ9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.addr_no_ack_flag <= 1'b0;
        end else begin
            sta_r.addr_no_ack_flag <= engine.addr_nack; // RQ11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.rx_request_flag <= 1'b0;
        end else begin
            sta_r.rx_request_flag <= engine.rx_not_empty; // RQ12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.tx_request_flag <= 1'b0;
        end else begin
            sta_r.tx_request_flag <= engine.addr_write_sent
                                   & (engine.tx_level != TX_LEVEL_FULL); // RQ14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.tx_fifo_level <= 2'h0;
        end else begin
            sta_r.tx_fifo_level <= engine.tx_level; // RQ16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_r.reserved <= 5'h0;
        end else begin
            sta_r.reserved <= 5'h0; // RQ17
        end
    end

    // ==========================================
    // Interrupt request
    logic irq_nxt;

    always_comb begin
        irq_nxt = (sta_r.xfer_complete_flag & en_complete)      // RQ5
                | (sta_r.data_no_ack_flag & en_noack)            // RQ6
                | (sta_r.addr_no_ack_flag & en_noack)            // RQ11
                | (sta_r.arbitration_lost_status & en_arb)       // RQ10
                | (sta_r.tx_request_flag & en_tx)                // RQ15
                | (sta_r.rx_request_flag & en_rx);               // RQ13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt; // RQ19
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_busy_set;
        start_det |=> sta_r.bus_busy_flag;
    endproperty
    a_busy_set: assert property (p_busy_set) // RQ1
        else $error("bus busy not set after start");

    property p_busy_clr;
        stop_det && !start_det |=> !sta_r.bus_busy_flag;
    endproperty
    a_busy_clr: assert property (p_busy_clr) // RQ2
        else $error("bus busy not cleared after stop");

    property p_ovf;
        (engine.rx_push && engine.rx_full) |=> sta_r.rx_overflow_flag
            ##1 (sta_r.rx_overflow_flag == $past(engine.rx_push && engine.rx_full));
    endproperty
    a_ovf: assert property (p_ovf) // RQ3
        else $error("rx overflow flag wrong");

    property p_xfer;
        engine.xfer_done |=> sta_r.xfer_complete_flag;
    endproperty
    a_xfer: assert property (p_xfer) // RQ4
        else $error("transfer complete flag missing");

    property p_xfer_irq;
        engine.xfer_done && en_complete ##1 en_complete |=> irq;
    endproperty
    a_xfer_irq: assert property (p_xfer_irq) // RQ5
        else $error("completion interrupt missing");

    property p_dnack;
        engine.data_nack && en_noack ##1 en_noack |-> sta_r.data_no_ack_flag ##1 irq;
    endproperty
    a_dnack: assert property (p_dnack) // RQ6
        else $error("data no-ack flag or interrupt missing");

    property p_mbusy;
        engine.engine_busy && !engine.arb_lost |=> sta_r.master_busy_flag;
    endproperty
    a_mbusy: assert property (p_mbusy) // RQ7
        else $error("master busy not set");

    property p_mbusy_clr;
        !engine.engine_busy || engine.arb_lost |=> !sta_r.master_busy_flag;
    endproperty
    a_mbusy_clr: assert property (p_mbusy_clr) // RQ8
        else $error("master busy not cleared");

    property p_arb;
        engine.arb_lost && en_arb ##1 en_arb
            |-> sta_r.arbitration_lost_status ##1 irq;
    endproperty
    a_arb: assert property (p_arb) // RQ9
        else $error("arbitration lost flag or interrupt missing");

    property p_anack;
        engine.addr_nack |=> sta_r.addr_no_ack_flag;
    endproperty
    a_anack: assert property (p_anack) // RQ11
        else $error("address no-ack flag missing");

    property p_rxq;
        sta_r.rx_request_flag == $past(engine.rx_not_empty);
    endproperty
    a_rxq: assert property (p_rxq) // RQ12
        else $error("receive request flag wrong");

    property p_txq;
        !engine.addr_write_sent || engine.tx_level == TX_LEVEL_FULL
            |=> !sta_r.tx_request_flag;
    endproperty
    a_txq: assert property (p_txq) // RQ14
        else $error("transmit request raised wrongly");

    property p_level;
        ##1 sta_r.tx_fifo_level == $past(engine.tx_level);
    endproperty
    a_level: assert property (p_level) // RQ16
        else $error("tx fifo level not reported");

    property p_rsvd;
        sta_read |-> prdata[STA_RSVD_HI:STA_RSVD_LO] == 5'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) // RQ17
        else $error("reserved status bits not zero");

    property p_irq_quiet;
        !(sta_r.xfer_complete_flag && en_complete)
            && !((sta_r.data_no_ack_flag || sta_r.addr_no_ack_flag) && en_noack)
            && !(sta_r.arbitration_lost_status && en_arb)
            && !(sta_r.tx_request_flag && en_tx)
            && !(sta_r.rx_request_flag && en_rx)
            |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) // RQ19
        else $error("interrupt without enabled source");

    c_start_stop: cover property (start_det ##[1:400] stop_det);
    c_xfer_irq: cover property (engine.xfer_done ##2 irq);
    c_sta_read: cover property (sta_read && sta_r.xfer_complete_flag);
    c_bad_addr: cover property (access && pslverr);

endmodule
`default_nettype wire

//--- i2c_master_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_status_flags_tb;
    import i2c_status_pkg::*;

    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                scl;
    logic                sda;
    engine_ev_s          engine;
    logic                irq;
    int                  failures;
    int                  n_checks;
    int                  cycles;

    i2c_master_status_flags #(.AW(12)) u_i2c_master_status_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
        .engine(engine), .irq(irq)
    );

    i2c_bus_peer u_i2c_bus_peer (.scl(scl), .sda(sda));

    // ==========================================
    // Clock and hang guard
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================
    // APB master
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        chk({31'h0, er}, {31'h0, exp_err});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, exp_err});
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // ==========================================
    // Scenarios
    task automatic regs_case;
        rd_chk(STA_OFFSET, 32'h0, 1'b0);
        rd_chk(CTL_OFFSET, 32'h0, 1'b0);
        wr_reg(CTL_OFFSET, 32'hffff_ffff, 1'b0);
        rd_chk(CTL_OFFSET, 32'h0000_ffff, 1'b0);
        irq_chk(1'b0);
        wr_reg(STA_OFFSET, 32'hffff_ffff, 1'b0);
        rd_chk(STA_OFFSET, 32'h0, 1'b0);
        wr_reg(12'h008, 32'h1234_5678, 1'b1);
        rd_chk(12'h008, 32'h0, 1'b1);
        wr_reg(CTL_OFFSET, 32'h0, 1'b0);
    endtask

    task automatic flag_case(input logic [10:0] ev, input logic [31:0] exp, input int en);
        @(posedge pclk);
        engine <= engine_ev_s'(ev);
        rd_chk(STA_OFFSET, exp, 1'b0);
        if (en >= 0) begin
            wr_reg(CTL_OFFSET, 32'h1f0 & ~(32'h1 << en), 1'b0);
            irq_chk(1'b0);
            wr_reg(CTL_OFFSET, 32'h1 << en, 1'b0);
            irq_chk(1'b1);
        end
        @(posedge pclk);
        engine <= '0;
        wr_reg(CTL_OFFSET, 32'h1f0, 1'b0);
        irq_chk(1'b0);
        wr_reg(CTL_OFFSET, 32'h0, 1'b0);
    endtask

    task automatic done_case;
        wr_reg(CTL_OFFSET, 32'h100, 1'b0);
        @(posedge pclk);
        engine <= engine_ev_s'(11'h080);
        @(posedge pclk);
        engine <= '0;
        irq_chk(1'b1);
        rd_chk(STA_OFFSET, 32'h100, 1'b0);
        rd_chk(STA_OFFSET, 32'h0, 1'b0);
        irq_chk(1'b0);
        wr_reg(CTL_OFFSET, 32'h0, 1'b0);
    endtask

    task automatic bus_case;
        u_i2c_bus_peer.start_cond();
        repeat (8) @(posedge pclk);
        rd_chk(STA_OFFSET, 32'h400, 1'b0);
        u_i2c_bus_peer.send_byte(8'ha5);
        rd_chk(STA_OFFSET, 32'h400, 1'b0);
        u_i2c_bus_peer.stop_cond();
        repeat (8) @(posedge pclk);
        rd_chk(STA_OFFSET, 32'h0, 1'b0);
    endtask

    task automatic reset_case;
        u_i2c_bus_peer.start_cond();
        @(posedge pclk);
        engine <= engine_ev_s'(11'h080);
        @(posedge pclk);
        engine <= '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(STA_OFFSET, 32'h0, 1'b0);
        u_i2c_bus_peer.stop_cond();
    endtask

    // ==========================================
    // Main sequence
    initial begin
        failures = 0;
        n_checks = 0;
        cycles   = 0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = '0;
        pwdata   = '0;
        engine   = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        regs_case();
        flag_case(11'h600, 32'h200, -1);
        flag_case(11'h200, 32'h000, -1);
        flag_case(11'h040, 32'h080, 7);
        flag_case(11'h020, 32'h010, 7);
        flag_case(11'h010, 32'h040, -1);
        flag_case(11'h018, 32'h020, 6);
        flag_case(11'h100, 32'h008, 4);
        flag_case(11'h004, 32'h004, 5);
        flag_case(11'h005, 32'h005, 5);
        flag_case(11'h006, 32'h006, -1);
        flag_case(11'h007, 32'h003, -1);
        flag_case(11'h001, 32'h001, -1);
        done_case();
        bus_case();
        reset_case();
        conclude();
    end
endmodule
`default_nettype wire

//--- i2c_status_pkg.sv
// Contract
// [RQ1] Bus-busy flag (bit 10) sets on any start condition seen on the bus.
// [RQ2] Bus-busy flag (bit 10) clears on a stop condition seen on the bus.
// [RQ3] Rx overflow flag (bit 9) high when a byte is pushed into full Rx FIFO.
// [RQ4] Transfer-complete flag (bit 8) sets when a master-slave transfer finishes.
// [RQ5] Transfer-complete flag with completion enable on raises the interrupt.
// [RQ6] Data no-ack flag (bit 7) on data-byte no-ack; interrupts if no-ack enable on.
// [RQ7] Master-busy flag (bit 6) high while the master engine processes a transaction.
// [RQ8] Master-busy flag low when engine idle or another master owns the bus.
// [RQ9] Arbitration-lost flag (bit 5) high when this master fails to win the bus.
// [RQ10] Arbitration-lost flag with its enable on raises the interrupt.
// [RQ11] Address no-ack flag (bit 4) on address no-ack; interrupts if no-ack enable on.
// [RQ12] Receive-request flag (bit 3) high when received data enters the Rx FIFO.
// [RQ13] Receive-request flag with receive enable on raises the interrupt.
// [RQ14] Transmit-request flag (bit 2) after address-plus-write while Tx FIFO holds 0 or 1.
// [RQ15] Transmit-request flag with transmit enable on raises the interrupt.
// [RQ16] Status bits 1:0 give Tx FIFO level: 00 empty, 01/10 one byte, 11 full.
// [RQ17] Status bits 15:11 are reserved and read as zero.
// [RQ18] Enables in control: complete 8, no-ack 7, arb-lost 6, transmit 5, receive 4.
// [RQ19] All enabled flag conditions merge into one interrupt output.
// [RQ20] All status flags are zero after system reset.
`default_nettype none
package i2c_status_pkg;

    // ==========================================
    // Register map
    localparam logic [11:0] CTL_OFFSET    = 12'h000;
    localparam logic [11:0] STA_OFFSET    = 12'h004;
    localparam logic [15:0] CTL_RESET     = 16'h0000;
    localparam logic [15:0] STA_RESET     = 16'h0000;

    // ==========================================
    // Control field positions
    localparam int CTL_COMPLETE_EN = 8;
    localparam int CTL_NOACK_EN    = 7;
    localparam int CTL_ARB_EN      = 6;
    localparam int CTL_TX_EN       = 5;
    localparam int CTL_RX_EN       = 4;
    localparam int CTL_USED_HI     = 8;

    // ==========================================
    // Status field positions
    localparam int STA_BUS_BUSY    = 10;
    localparam int STA_RX_OVF      = 9;
    localparam int STA_XFER_DONE   = 8;
    localparam int STA_DATA_NACK   = 7;
    localparam int STA_MST_BUSY    = 6;
    localparam int STA_ARB_LOST    = 5;
    localparam int STA_ADDR_NACK   = 4;
    localparam int STA_RX_REQ      = 3;
    localparam int STA_TX_REQ      = 2;
    localparam int STA_RSVD_LO     = 11;
    localparam int STA_RSVD_HI     = 15;
    localparam logic [1:0] TX_LEVEL_FULL = 2'h3;

    // ==========================================
    // Engine events into the flag logic
    typedef struct packed {
        logic       rx_push;
        logic       rx_full;
        logic       rx_not_empty;
        logic       xfer_done;
        logic       data_nack;
        logic       addr_nack;
        logic       engine_busy;
        logic       arb_lost;
        logic       addr_write_sent;
        logic [1:0] tx_level;
    } engine_ev_s;

    // Status register image
    typedef struct packed {
        logic [4:0] reserved;
        logic       bus_busy_flag;
        logic       rx_overflow_flag;
        logic       xfer_complete_flag;
        logic       data_no_ack_flag;
        logic       master_busy_flag;
        logic       arbitration_lost_status;
        logic       addr_no_ack_flag;
        logic       rx_request_flag;
        logic       tx_request_flag;
        logic [1:0] tx_fifo_level;
    } status_s;

endpackage
`default_nettype wire

//--- sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    // ==========================================
    // Two-stage synchroniser
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= '1;
            sync_out <= '1;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire
